// File: etc_pkg.sv
// Constants and types shared by the E1 transmit and common control block.
// Assumes a byte-wide register port and a framer clocked well above the line rate.
package etc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_TX_CONTROL_ONE = 8'h12;
	localparam logic [7:0] ADDR_TX_CONTROL_TWO = 8'h13;
	localparam logic [7:0] ADDR_COMMON_LINE_CONTROL_ONE = 8'h14;
	localparam logic [7:0] ADDR_FRAMER_STATUS = 8'h15;
	localparam logic [7:0] ADDR_TX_ALIGN_FRAME = 8'h16;
	localparam logic [7:0] ADDR_TX_NONALIGN_FRAME = 8'h17;
	localparam logic [7:0] ADDR_SIGNALING_FIRST = 8'h20;
	localparam logic [7:0] ADDR_SIGNALING_LAST = 8'h2F;
	localparam logic [7:0] REG_RESET_VALUE = 8'h00;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int OUTPUT_FORMAT_SELECT = 7;
	localparam int TS_ZERO_PASS_THROUGH = 6;
	localparam int TS_SIXTEEN_SOURCE_SELECT = 5;
	localparam int UNFRAMED_ONES_FORCE = 4;
	localparam int INTL_BIT_SOURCE_SELECT = 3;
	localparam int SIGNALING_ONES_FORCE = 2;
	localparam int TX_SYNC_MODE = 1;
	localparam int TX_SYNC_DIRECTION = 0;

	localparam int PULSE_WIDTH_MODE = 2;
	localparam int AUTO_EBIT_ENABLE = 1;
	localparam int PIN_FUNCTION_SELECT = 0;

	localparam int FRAMER_LOOPBACK_ENABLE = 7;
	localparam int TX_LINE_CODE_ENABLE = 6;
	localparam int TX_G_EIGHT_OH_TWO_ENABLE = 5;
	localparam int TX_CHECKSUM_ENABLE = 4;
	localparam int RX_SIGNALING_MODE = 3;
	localparam int RX_LINE_CODE_ENABLE = 2;
	localparam int RX_G_EIGHT_OH_TWO_ENABLE = 1;
	localparam int RX_CHECKSUM_ENABLE = 0;

	// ****************************************
	// Frame structure
	// ****************************************
	localparam logic [7:0] LAST_BIT_OF_FRAME = 8'hFF;
	localparam logic [4:0] TS_ALIGN = 5'h00;
	localparam logic [4:0] TS_SIGNALING = 5'h10;
	localparam logic [3:0] FIRST_EBIT_FRAME = 4'hC;
	localparam logic [2:0] LAST_FRAME_OF_SUBMF = 3'h7;
	localparam logic [5:0] MF_ALIGN_PATTERN = 6'h0B;

	typedef enum logic [1:0] {
		MARK_ZERO,
		MARK_PULSE,
		MARK_BALANCE,
		MARK_VIOLATION
	} etc_mark_type;

endpackage : etc_pkg

// File: etc_hdb3_encoder.sv
// Line coder for the transmit bit stream: AMI, optionally with HDB3 substitution.
// Assumes one shift strobe per transmitted bit from logic on the same clock.
`timescale 1ns/1ps

module etc_hdb3_encoder
	import etc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic shift,
	input wire logic bit_in,
	input wire logic hdb3_enable,
	output logic line_pos,
	output logic line_neg
);

	typedef struct packed {
		etc_mark_type [3:0] window;
		logic odd_pulses;
		logic last_pol;
		logic pos;
		logic neg;
	} etc_enc_state_type;

	etc_enc_state_type s;
	etc_enc_state_type n;

	// ****************************************
	// Four-bit look-ahead window
	// ****************************************
	// The window delays AMI by four bits too, so both codes share one latency.
	always_comb begin
		etc_mark_type incoming;
		incoming = MARK_ZERO;
		n = s;
		if (shift) begin
			incoming = bit_in ? MARK_PULSE : MARK_ZERO;
			if (incoming == MARK_PULSE) begin
				n.odd_pulses = ~s.odd_pulses;
			end
			n.window[3:1] = s.window[2:0];
			n.window[0] = incoming;
			if (hdb3_enable && !bit_in && s.window[0] == MARK_ZERO &&
				s.window[1] == MARK_ZERO && s.window[2] == MARK_ZERO) begin
				n.window[0] = MARK_VIOLATION;
				n.window[3] = s.odd_pulses ? MARK_ZERO : MARK_BALANCE;
				n.odd_pulses = 1'b0;
			end
			n.pos = 1'b0;
			n.neg = 1'b0;
			unique case (s.window[3])
				MARK_ZERO: begin
				end
				MARK_PULSE, MARK_BALANCE: begin
					n.last_pol = ~s.last_pol;
					n.pos = ~s.last_pol;
					n.neg = s.last_pol;
				end
				MARK_VIOLATION: begin
					n.pos = s.last_pol;
					n.neg = ~s.last_pol;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign line_pos = s.pos;
	assign line_neg = s.neg;

endmodule : etc_hdb3_encoder

// File: etc_tx_common_control.sv
// Transmit formatter and common line control of one E1 framer.
// Assumes line-side pins arrive asynchronously and are resynchronised here.
`timescale 1ns/1ps

module etc_tx_common_control
	import etc_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic TX_CLOCK_IN,
	input wire logic TX_SERIAL_INPUT,
	input wire logic TX_SYNC_PIN_IN,
	output logic TX_SYNC_PIN_OUT,
	output logic TX_SYNC_PIN_OE,
	output logic TX_LINE_POSITIVE,
	output logic TX_LINE_NEGATIVE,
	input wire logic RX_CLOCK_IN,
	input wire logic RX_LINE_POSITIVE,
	input wire logic RX_LINE_NEGATIVE,
	input wire logic RX_SUBMF_ERROR,
	output logic RX_CLOCK_OUT,
	output logic RX_DATA,
	output logic RX_SIGNALING_MODE_OUT,
	output logic RX_CHECKSUM_ENABLE_OUT
);

	typedef struct packed {
		logic [7:0] tx_control_one;
		logic [7:0] tx_control_two;
		logic [7:0] common_line_control_one;
		logic [7:0] tx_align_frame_reg;
		logic [7:0] tx_nonalign_frame_reg;
		logic [15:0][7:0] signaling_reg;
		logic [7:0] rdata;
		logic [5:0] meta;
		logic [5:0] sync;
		logic tx_clock_in_prev;
		logic rclk_prev;
		logic tx_sync_pin_prev;
		logic [7:0] bit_cnt;
		logic [3:0] frame;
		logic [3:0] crc;
		logic [3:0] crc_hold;
		logic ebit_error;
		logic tick_d;
		logic line_bit;
		logic tx_pos;
		logic tx_neg;
		logic sync_out;
		logic [2:0] rx_window;
		logic rx_last_pol;
		logic rx_data;
		logic rx_clk;
	} etc_state_type;

	etc_state_type s;
	etc_state_type n;

	logic tx_clock_in_rise;
	logic tx_bit;
	logic enc_pos;
	logic enc_neg;

	// ****************************************
	// Line coder
	// ****************************************
	etc_hdb3_encoder u_encoder (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.shift(tx_clock_in_rise),
		.bit_in(tx_bit),
		.hdb3_enable(s.common_line_control_one[TX_LINE_CODE_ENABLE]),
		.line_pos(enc_pos),
		.line_neg(enc_neg)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic tx_clock_in;
		logic rclk;
		logic tx_serial_input;
		logic tx_sync_pin_in;
		logic tx_clock_in_fall;
		logic rclk_rise;
		logic [4:0] ts;
		logic [2:0] k;
		logic fas;
		logic si;
		logic si_src;
		logic ebit_slot;
		logic ebit_sent;
		logic crc_in;
		logic fb;
		logic [3:0] crc_next;
		logic loop;
		logic rx_strobe;
		logic rx_line_positive;
		logic rx_line_negative;
		logic pulse;
		logic viol;
		logic [2:0] win;
		tx_clock_in = s.sync[0];
		tx_serial_input = s.sync[1];
		tx_sync_pin_in = s.sync[2];
		rclk = s.sync[3];
		n = s;
		n.meta = {RX_LINE_NEGATIVE, RX_LINE_POSITIVE, RX_CLOCK_IN, TX_SYNC_PIN_IN,
			TX_SERIAL_INPUT, TX_CLOCK_IN};
		n.sync = s.meta;
		n.tx_clock_in_prev = tx_clock_in;
		n.rclk_prev = rclk;
		n.tx_sync_pin_prev = tx_sync_pin_in;
		tx_clock_in_rise = tx_clock_in & ~s.tx_clock_in_prev;
		tx_clock_in_fall = ~tx_clock_in & s.tx_clock_in_prev;
		rclk_rise = rclk & ~s.rclk_prev;
		loop = s.common_line_control_one[FRAMER_LOOPBACK_ENABLE];

		// Register port
		if (WR) begin
			unique case (ADDR)
				ADDR_TX_CONTROL_ONE: n.tx_control_one = WDATA;
				ADDR_TX_CONTROL_TWO: n.tx_control_two = WDATA;
				ADDR_COMMON_LINE_CONTROL_ONE: n.common_line_control_one = WDATA;
				ADDR_TX_ALIGN_FRAME: n.tx_align_frame_reg = WDATA;
				ADDR_TX_NONALIGN_FRAME: n.tx_nonalign_frame_reg = WDATA;
				default: begin
					if (ADDR >= ADDR_SIGNALING_FIRST && ADDR <= ADDR_SIGNALING_LAST) begin
						n.signaling_reg[ADDR[3:0]] = WDATA;
					end
				end
			endcase
		end
		n.rdata = 8'h00;
		if (RD) begin
			unique case (ADDR)
				ADDR_TX_CONTROL_ONE: n.rdata = s.tx_control_one;
				ADDR_TX_CONTROL_TWO: n.rdata = s.tx_control_two;
				ADDR_COMMON_LINE_CONTROL_ONE: n.rdata = s.common_line_control_one;
				ADDR_FRAMER_STATUS: n.rdata = {loop, 3'h0, s.frame};
				ADDR_TX_ALIGN_FRAME: n.rdata = s.tx_align_frame_reg;
				ADDR_TX_NONALIGN_FRAME: n.rdata = s.tx_nonalign_frame_reg;
				default: begin
					if (ADDR >= ADDR_SIGNALING_FIRST && ADDR <= ADDR_SIGNALING_LAST) begin
						n.rdata = s.signaling_reg[ADDR[3:0]];
					end
				end
			endcase
		end

		// Transmit bit selection; bit 1 of a timeslot goes out first
		ts = s.bit_cnt[7:3];
		k = s.bit_cnt[2:0];
		fas = ~s.frame[0];
		ebit_slot = 1'b0;
		si_src = tx_serial_input;
		if (s.tx_control_one[INTL_BIT_SOURCE_SELECT]) begin
			si_src = fas ? s.tx_align_frame_reg[7] : s.tx_nonalign_frame_reg[7];
		end
		si = si_src;
		if (s.common_line_control_one[TX_CHECKSUM_ENABLE]) begin
			if (fas) begin
				si = s.crc_hold[~s.frame[2:1]];
			end else if (s.frame < FIRST_EBIT_FRAME) begin
				si = MF_ALIGN_PATTERN[3'd5 - s.frame[3:1]];
			end else begin
				ebit_slot = 1'b1;
				if (s.tx_control_two[AUTO_EBIT_ENABLE]) begin
					si = ~s.ebit_error;
				end
			end
		end
		tx_bit = tx_serial_input;
		if (ts == TS_ALIGN) begin
			if (k == 3'h0) begin
				tx_bit = si;
			end else if (s.tx_control_one[TS_ZERO_PASS_THROUGH]) begin
				tx_bit = tx_serial_input;
			end else begin
				tx_bit = fas ? s.tx_align_frame_reg[~k] : s.tx_nonalign_frame_reg[~k];
			end
		end else if (ts == TS_SIGNALING) begin
			if (s.tx_control_one[SIGNALING_ONES_FORCE]) begin
				tx_bit = 1'b1;
			end else if (s.tx_control_one[TS_SIXTEEN_SOURCE_SELECT]) begin
				tx_bit = s.signaling_reg[s.frame][~k];
			end
		end
		if (s.tx_control_one[UNFRAMED_ONES_FORCE]) begin
			tx_bit = 1'b1;
		end

		// Checksum runs with its own C-bit slots taken as zero
		crc_in = (ts == TS_ALIGN && k == 3'h0 && fas) ? 1'b0 : tx_bit;
		fb = crc_in ^ s.crc[3];
		crc_next = {s.crc[2], s.crc[1], s.crc[0] ^ fb, fb};
		ebit_sent = 1'b0;
		n.tick_d = tx_clock_in_rise;
		if (tx_clock_in_rise) begin
			n.line_bit = tx_bit;
			n.crc = crc_next;
			n.bit_cnt = s.bit_cnt + 8'h01;
			n.sync_out = (s.bit_cnt == 8'h00) &&
				(!s.tx_control_one[TX_SYNC_MODE] || s.frame == 4'h0);
			ebit_sent = ebit_slot && ts == TS_ALIGN && k == 3'h0 &&
				s.tx_control_two[AUTO_EBIT_ENABLE];
			if (s.bit_cnt == LAST_BIT_OF_FRAME) begin
				n.frame = s.frame + 4'h1;
				if (s.frame[2:0] == LAST_FRAME_OF_SUBMF) begin
					n.crc_hold = crc_next;
					n.crc = 4'h0;
				end
			end
		end
		// A new error beats the clear caused by reporting the previous one
		n.ebit_error = (s.ebit_error & ~ebit_sent) | RX_SUBMF_ERROR;

		// Sync pin as input realigns the bit counter, and the frame counter too when TX_SYNC_MODE is set
		if (!s.tx_control_one[TX_SYNC_DIRECTION] && tx_sync_pin_in && !s.tx_sync_pin_prev) begin
			n.bit_cnt = 8'h00;
			if (s.tx_control_one[TX_SYNC_MODE]) begin
				n.frame = 4'h0;
			end
		end

		// Output shaping
		if (s.tick_d) begin
			if (s.tx_control_one[OUTPUT_FORMAT_SELECT]) begin
				n.tx_pos = s.line_bit;
				n.tx_neg = 1'b0;
			end else begin
				n.tx_pos = enc_pos;
				n.tx_neg = enc_neg;
			end
		end else if (tx_clock_in_fall && s.tx_control_two[PULSE_WIDTH_MODE]) begin
			n.tx_pos = 1'b0;
			n.tx_neg = 1'b0;
		end

		// Receive side: line inputs or the looped transmit marks
		rx_strobe = loop ? tx_clock_in_rise : rclk_rise;
		rx_line_positive = loop ? enc_pos : s.sync[4];
		rx_line_negative = loop ? enc_neg : s.sync[5];
		pulse = rx_line_positive | rx_line_negative;
		viol = s.common_line_control_one[RX_LINE_CODE_ENABLE] && pulse &&
			(rx_line_positive == s.rx_last_pol);
		win = s.rx_window;
		if (viol) begin
			win[2] = 1'b0;
		end
		if (rx_strobe) begin
			n.rx_data = win[2];
			n.rx_window = {win[1:0], pulse & ~viol};
			if (pulse) begin
				n.rx_last_pol = rx_line_positive;
			end
		end
		n.rx_clk = loop ? tx_clock_in : rclk;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign RDATA = s.rdata;
	assign TX_SYNC_PIN_OUT = s.sync_out;
	assign TX_SYNC_PIN_OE = s.tx_control_one[TX_SYNC_DIRECTION];
	assign TX_LINE_POSITIVE = s.tx_pos;
	assign TX_LINE_NEGATIVE = s.tx_neg;
	assign RX_CLOCK_OUT = s.rx_clk;
	assign RX_DATA = s.rx_data;
	assign RX_SIGNALING_MODE_OUT = s.common_line_control_one[RX_SIGNALING_MODE];
	assign RX_CHECKSUM_ENABLE_OUT = s.common_line_control_one[RX_CHECKSUM_ENABLE];

endmodule : etc_tx_common_control

// File: etc_checker.sv
// Assertions on the ports of the transmit and common control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps

module etc_checker
	import etc_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire logic TX_CLOCK_IN,
	input wire logic TX_SYNC_PIN_OE,
	input wire logic TX_LINE_POSITIVE,
	input wire logic TX_LINE_NEGATIVE,
	input wire logic RX_CLOCK_OUT,
	input wire logic RX_SIGNALING_MODE_OUT,
	input wire logic RX_CHECKSUM_ENABLE_OUT
);
	// *****
	// Shadow registers, age counts cycles since the last write
	// *****
	typedef struct packed {
		logic [7:0] t1;
		logic [7:0] t2;
		logic [7:0] c1;
		logic [7:0] age;
	} etc_shadow_type;
	etc_shadow_type s;
	etc_shadow_type next_s;
	// Line checks wait long enough for the 4-bit encoder pipe to refill
	wire settled = s.age >= 8'h04;
	wire warm = s.age == 8'hFF;

	always_comb begin
		next_s = s;
		if (s.age != 8'hFF) next_s.age = s.age + 8'h01;
		if (WR) begin
			next_s.age = 8'h00;
			if (ADDR == ADDR_TX_CONTROL_ONE) next_s.t1 = WDATA;
			if (ADDR == ADDR_TX_CONTROL_TWO) next_s.t2 = WDATA;
			if (ADDR == ADDR_COMMON_LINE_CONTROL_ONE) next_s.c1 = WDATA;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) s <= '0;
		else s <= next_s;
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_tick;
		$rose(TX_CLOCK_IN);
	endsequence
	sequence s_fall;
		$fell(TX_CLOCK_IN);
	endsequence

	a_bipolar_excl: assert property (!(TX_LINE_POSITIVE && TX_LINE_NEGATIVE))
		else $error("both line outputs high");
	a_nrz_neg: assert property (warm && s.t1[7] |-> !TX_LINE_NEGATIVE)
		else $error("negative output high in NRZ");
	a_nrz_ones: assert property (warm && s.t1[7] && s.t1[4] && !s.t2[2]
		|-> TX_LINE_POSITIVE)
		else $error("NRZ ones not continuous");
	a_ones_marks: assert property (warm && s.t1[4] && !s.t1[7] ##0 s_tick
		|-> ##[2:6] (TX_LINE_POSITIVE || TX_LINE_NEGATIVE))
		else $error("missing mark in all ones");
	a_half_width: assert property (warm && s.t2[2] && !s.t1[7] ##0 s_fall
		|-> ##[2:6] !(TX_LINE_POSITIVE || TX_LINE_NEGATIVE))
		else $error("pulse not cut at half period");
	a_sync_dir: assert property (settled |-> TX_SYNC_PIN_OE == s.t1[0])
		else $error("sync pin direction wrong");
	a_sig_mode: assert property (settled |-> RX_SIGNALING_MODE_OUT == s.c1[3])
		else $error("signaling mode wrong");
	a_crc_follow: assert property (settled |-> RX_CHECKSUM_ENABLE_OUT == s.c1[0])
		else $error("receive checksum enable wrong");
	a_loop_clock: assert property (warm && s.c1[7] ##0 s_tick
		|-> ##[2:5] $rose(RX_CLOCK_OUT))
		else $error("loopback receive clock not from transmit clock");
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read slot");
endmodule : etc_checker

bind etc_tx_common_control etc_checker chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.TX_CLOCK_IN(TX_CLOCK_IN), .TX_SYNC_PIN_OE(TX_SYNC_PIN_OE),
	.TX_LINE_POSITIVE(TX_LINE_POSITIVE), .TX_LINE_NEGATIVE(TX_LINE_NEGATIVE),
	.RX_CLOCK_OUT(RX_CLOCK_OUT), .RX_SIGNALING_MODE_OUT(RX_SIGNALING_MODE_OUT),
	.RX_CHECKSUM_ENABLE_OUT(RX_CHECKSUM_ENABLE_OUT));

// File: etc_line_model.sv
// Line interface and backplane model: free line clocks, AMI receive line,
// fixed serial pattern. Assumes run rises once reset is released.
`timescale 1ns/1ps

module etc_line_model (
	input wire logic run,
	output logic tx_clk,
	output logic rx_clk,
	output logic rx_pos,
	output logic rx_neg,
	output logic tx_ser
);
	// *****
	// Clocks and data
	// *****
	logic [7:0] pat;
	logic [1:0] rx_ph;
	initial begin
		tx_clk = 1'b0;
		rx_clk = 1'b0;
		rx_pos = 1'b0;
		rx_neg = 1'b0;
		rx_ph = 2'h0;
		tx_ser = 1'b0;
		pat = 8'hA5;
	end
	// Unequal rates so a loopback clock cannot pass by chance
	always #400 if (run) tx_clk = ~tx_clk;
	always #300 if (run) rx_clk = ~rx_clk;
	always @(negedge tx_clk) begin
		pat = {pat[6:0], pat[7]};
		tx_ser = pat[7];
	end
	// Marks on every other bit, so received data alternates and loopback shows
	always @(posedge rx_clk) begin
		rx_ph = rx_ph + 2'h1;
		rx_pos = rx_ph == 2'h1;
		rx_neg = rx_ph == 2'h3;
	end
endmodule : etc_line_model

// File: tb_top.sv
// Self-checking bench for the transmit and common control block.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps

module tb_top;
	import etc_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} etc_row_type;
	logic ref_clk, rst_n, wr_stb, rd_stb, run;
	logic [7:0] addr, wdata, rdata, d;
	logic tx_clock_in, rclk, rx_line_positive, rx_line_negative, tx_serial_input, oe, spo, tp, tn, rco, rx_signaling_mode, rcrc, rdo, tsi;
	int fails, checks, np, nn, ns, nr, nt, nd, c;
	// Unmapped writes must vanish
	etc_row_type rows [4] = '{'{ADDR_TX_CONTROL_ONE, 8'h29, 8'h29},
		'{ADDR_TX_CONTROL_TWO, 8'hFE, 8'hFE},
		'{ADDR_COMMON_LINE_CONTROL_ONE, 8'hD9, 8'hD9}, '{8'h40, 8'hFF, 8'h00}};

	etc_tx_common_control dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr_stb), .RD(rd_stb), .RDATA(rdata), .TX_CLOCK_IN(tx_clock_in),
		.TX_SERIAL_INPUT(tx_serial_input), .TX_SYNC_PIN_IN(tsi), .TX_SYNC_PIN_OUT(spo),
		.TX_SYNC_PIN_OE(oe), .TX_LINE_POSITIVE(tp), .TX_LINE_NEGATIVE(tn),
		.RX_CLOCK_IN(rclk), .RX_LINE_POSITIVE(rx_line_positive), .RX_LINE_NEGATIVE(rx_line_negative),
		.RX_SUBMF_ERROR(1'b0), .RX_CLOCK_OUT(rco), .RX_DATA(rdo),
		.RX_SIGNALING_MODE_OUT(rx_signaling_mode), .RX_CHECKSUM_ENABLE_OUT(rcrc));
	etc_line_model line_u (.run(run), .tx_clk(tx_clock_in), .rx_clk(rclk), .rx_pos(rx_line_positive),
		.rx_neg(rx_line_negative), .tx_ser(tx_serial_input));

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// *****
	// Bus, compare and watch tasks
	// *****
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic watch(input int n);
		logic ps, pr, pt;
		{np, nn, ns, nr, nt, nd} = '0;
		{ps, pr, pt} = {spo, rco, tx_clock_in};
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			np += int'(tp);
			nn += int'(tn);
			ns += int'(spo && !ps);
			nr += int'(rco && !pr);
			nt += int'(tx_clock_in && !pt);
			nd += int'(!rdo);
			{ps, pr, pt} = {spo, rco, tx_clock_in};
		end
	endtask : watch
	task automatic to_rise();
		logic p;
		c = 0;
		p = 1'b1;
		while (!(spo === 1'b1 && !p)) begin
			p = spo;
			@(posedge ref_clk);
			#1;
			c++;
			if (c > 5000) begin
				fails++;
				report_and_stop();
			end
		end
	endtask : to_rise
	task automatic setup(input logic [7:0] t1, input logic [7:0] t2, input logic [7:0] c1);
		wr(ADDR_COMMON_LINE_CONTROL_ONE, c1);
		wr(ADDR_TX_CONTROL_TWO, t2);
		wr(ADDR_TX_CONTROL_ONE, t1);
		repeat (300) @(posedge ref_clk);
		watch(800);
	endtask : setup
	// NRZ shows bit b of the frame for 16 cycles, one cycle after the sync rise
	task automatic slice(input logic [7:0] t1, input int first, input int bits);
		setup(t1, 8'h00, 8'h00);
		to_rise();
		repeat (16 * first) @(posedge ref_clk);
		watch(16 * bits);
	endtask : slice
	task automatic report_and_stop();
		$display("TB: checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop

	// *****
	// Main sequence
	// *****
	initial begin
		{rst_n, wr_stb, rd_stb, run, tsi, addr, wdata, fails, checks} = '0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		run <= 1'b1;
		foreach (rows[i]) begin
			rd(rows[i].a);
			chk(d, REG_RESET_VALUE);
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a);
			chk(d, rows[i].e);
		end
		$display("TB: registers done");
		setup(8'h11, 8'h00, 8'h00);
		chk(np + nn, 800);
		chk(32'(np > 300 && nn > 300), 1);
		chk(oe, 1);
		chk(32'(nd inside {[200:600]}), 1);
		setup(8'h11, 8'h04, 8'h00);
		chk(32'(np + nn inside {[200:500]}), 1);
		setup(8'h91, 8'h00, 8'h00);
		chk(np, 800);
		chk(nn, 0);
		$display("TB: line formats done");
		setup(8'h11, 8'h00, 8'h89);
		chk(np + nn, 800);
		chk(32'(nr inside {[nt - 1:nt + 1]}), 1);
		chk({rx_signaling_mode, rcrc}, 2'b11);
		chk(nd, 0);
		$display("TB: loopback done");
		setup(8'h01, 8'h00, 8'h00);
		to_rise();
		to_rise();
		chk(c, (int'(LAST_BIT_OF_FRAME) + 1) * 16);
		setup(8'h03, 8'h00, 8'h00);
		watch(8192);
		chk(32'(ns <= 1), 1);
		wr(ADDR_TX_CONTROL_ONE, 8'h00);
		to_rise();
		repeat (40) @(posedge ref_clk);
		tsi <= 1'b1;
		to_rise();
		chk(32'(c < 24), 1);
		@(posedge ref_clk);
		tsi <= 1'b0;
		$display("TB: sync modes done");
		slice(8'h81, 1, 7);
		chk(np, 0);
		slice(8'hC1, 1, 7);
		chk(32'(np > 0), 1);
		slice(8'h89, 0, 1);
		chk(np, 0);
		slice(8'hA1, 128, 8);
		chk(np, 0);
		slice(8'h85, 128, 8);
		chk(np, 128);
		$display("TB: timeslot sources done");
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(ADDR_TX_CONTROL_ONE);
		chk({d, oe}, 9'h000);
		$display("TB: second reset done");
		report_and_stop();
	end
endmodule : tb_top
